// ### hw/cbr_cfg.svh
`ifndef CBR_CFG_SVH
`define CBR_CFG_SVH
// buffer ram: byte wide, 16k entries
`define CBR_BUF_AW 14
`define CBR_BUF_DW 8
`define CBR_BUF_DEPTH 16384
// descriptor table ram: 128-bit words, 144 entries
`define CBR_DT_AW 8
`define CBR_DT_DW 128
`define CBR_DT_DEPTH 144
// first word of the descriptor sub-table inside the descriptor table ram
`define CBR_DT_DESC_BASE 8'h00
// descriptor word field positions
`define CBR_DF_TYPE_LSB 0
`define CBR_DF_BASE_LSB 2
`define CBR_DF_SIZE_LSB 16
`define CBR_DF_SUB_LSB 31
`define CBR_DF_EN_BIT 45
// field widths
`define CBR_SIZE_W 15
`define CBR_PC_W 8
// reset values
`define CBR_PTR_RST 14'h0000
`define CBR_PC_RST 8'h00
// host fifo depth
`define CBR_FIFO_DEPTH 16
`endif

// ### hw/cbr_pkg.sv
`include "cbr_cfg.svh"
`default_nettype none
package cbr_pkg;
    typedef enum logic [1:0] {
        CBR_SYNC = 2'h0,
        CBR_ISOC = 2'h1,
        CBR_ASYNC = 2'h2,
        CBR_CTRL = 2'h3
    } cbr_ctype_t;

    // last buffer ram grant, one-hot
    typedef enum logic [1:0] {
        CBR_GNT_WR = 2'h1,
        CBR_GNT_RD = 2'h2
    } cbr_gnt_t;

    typedef logic [`CBR_BUF_AW-1:0] cbr_ptr_t;
    typedef logic [`CBR_SIZE_W-1:0] cbr_size_t;
    typedef logic [`CBR_PC_W-1:0] cbr_pc_t;

    typedef struct packed {
        logic active;
        cbr_ctype_t ctype;
        cbr_ptr_t base;
        cbr_size_t size;
        cbr_ptr_t sub;
        cbr_ptr_t wstart;
        cbr_ptr_t write_pointer;
        cbr_ptr_t read_pointer;
        logic buffer_full_flag;
        cbr_pc_t write_packet_count;
        cbr_pc_t read_packet_count;
    } cbr_chan_t;
endpackage
`default_nettype wire

// ### hw/cbr_routing_fabric.sv
// Operation
// - arbiter and muxes share both external rams
// - channel descriptors govern each buffer access
// - buffer ram addressing covers 16k bytes
// - buffer ram gives circular buffering per channel
// - receive keeps write pointer, transmit read pointer
// - per-type full/empty detection prevents over/underflow
// - sync read pointer trails write by two sub-buffers
// - sync pointers jump to next sub-buffer on sync
// - isochronous never reads empty nor writes full
// - isochronous empty: pointers equal, full flag clear
// - isochronous full: pointers equal, full flag set
// - async/control judged by pointers and packet counts
// - async empty: pointers equal, counts equal
// - async full: equal pointers differing counts, or count-1
// - descriptor ram is 144 words of 128 bits
// - descriptor table is one of three sub-tables
`include "cbr_cfg.svh"
`default_nettype none

module cbr_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } cbr_fifo_st_t;
    cbr_fifo_st_t s;
    cbr_fifo_st_t next_s;
    logic push;
    logic pop;

    assign in_ready = s.cnt != (AW+1)'(D);
    assign out_valid = s.cnt != '0;
    assign out_data = s.mem[s.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == (AW)'(D-1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == (AW)'(D-1)) ? '0 : s.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

module cbr_routing_fabric #(
    parameter int N = 4,
    parameter int CW = 2,
    parameter int FIFO_DEPTH = `CBR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // channel control and status
    input wire logic [N-1:0] CH_LOAD,
    input wire logic FRAME_SYNC,
    output logic [N-1:0] CH_ACTIVE,
    output logic [N-1:0] CH_EMPTY,
    output logic [N-1:0] CH_FULL,
    // media bus port, receive side writes into the buffers
    input wire logic MEDIA_VALID,
    output logic MEDIA_READY,
    input wire logic [CW-1:0] MEDIA_CH,
    input wire logic [`CBR_BUF_DW-1:0] MEDIA_DATA,
    input wire logic MEDIA_LAST,
    // host bus port, read requests
    input wire logic HOST_REQ_VALID,
    output logic HOST_REQ_READY,
    input wire logic [CW-1:0] HOST_REQ_CH,
    input wire logic HOST_REQ_LAST,
    // host bus port, read data
    output logic HOST_VALID,
    input wire logic HOST_READY,
    output logic [CW-1:0] HOST_CH,
    output logic HOST_LAST,
    output logic [`CBR_BUF_DW-1:0] HOST_DATA,
    // buffer ram
    output logic [`CBR_BUF_AW-1:0] BUF_ADDR,
    output logic BUF_WE,
    output logic BUF_RE,
    output logic [`CBR_BUF_DW-1:0] BUF_WDATA,
    input wire logic [`CBR_BUF_DW-1:0] BUF_RDATA,
    // descriptor table ram
    output logic [`CBR_DT_AW-1:0] DT_ADDR,
    output logic DT_RE,
    input wire logic [`CBR_DT_DW-1:0] DT_RDATA
);
    import cbr_pkg::*;

    localparam int FW = `CBR_BUF_DW + CW + 1;

    typedef struct packed {
        cbr_chan_t [N-1:0] ch;
        logic fs1;
        logic fs2;
        logic fs3;
        logic [N-1:0] dt_pend;
        logic [CW-1:0] dt_rr;
        logic dt_p1v;
        logic [CW-1:0] dt_p1ch;
        logic dt_p2v;
        logic [CW-1:0] dt_p2ch;
        logic [`CBR_DT_AW-1:0] dt_addr;
        logic dt_re;
        cbr_gnt_t last;
        logic [`CBR_BUF_AW-1:0] buf_addr;
        logic buf_we;
        logic buf_re;
        logic [`CBR_BUF_DW-1:0] buf_wdata;
        logic rd_p1v;
        logic [CW-1:0] rd_p1ch;
        logic rd_p1last;
        logic rd_p2v;
        logic [CW-1:0] rd_p2ch;
        logic rd_p2last;
    } cbr_state_t;

    cbr_state_t s;
    cbr_state_t next_s;
    logic [N-1:0] empty;
    logic [N-1:0] full;
    logic fifo_in_ready;
    logic [FW-1:0] fifo_out;

    // wrap-around step of a buffer offset
    function automatic cbr_ptr_t ptr_inc(input cbr_ptr_t p, input cbr_size_t size);
        cbr_size_t nx;
        nx = {1'b0, p} + 1'b1;
        ptr_inc = (nx >= size) ? '0 : nx[`CBR_BUF_AW-1:0];
    endfunction

    // offset two sub-buffers behind w, modulo the buffer size
    function automatic cbr_ptr_t ptr_rewind(input cbr_ptr_t w, input cbr_ptr_t sub, input cbr_size_t size);
        cbr_size_t two;
        cbr_size_t r;
        two = {sub, 1'b0};
        r = ({1'b0, w} >= two) ? ({1'b0, w} - two) : ({1'b0, w} + size - two);
        ptr_rewind = r[`CBR_BUF_AW-1:0];
    endfunction

    // start of the sub-buffer after w
    function automatic cbr_ptr_t ptr_next_sub(input cbr_ptr_t w, input cbr_ptr_t sub, input cbr_size_t size);
        cbr_size_t r;
        r = {1'b0, w} + {1'b0, sub};
        if (r >= size) begin
            r = r - size;
        end
        ptr_next_sub = r[`CBR_BUF_AW-1:0];
    endfunction

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_stat
            logic eq;
            logic pc_eq;
            logic pc_wrap;
            assign eq = s.ch[g].write_pointer == s.ch[g].read_pointer;
            assign pc_eq = s.ch[g].write_packet_count == s.ch[g].read_packet_count;
            assign pc_wrap = s.ch[g].write_packet_count == (s.ch[g].read_packet_count - 1'b1);
            always_comb begin
                empty[g] = 1'b0;
                full[g] = 1'b0;
                case (s.ch[g].ctype)
                    CBR_ISOC: begin
                        empty[g] = eq && !s.ch[g].buffer_full_flag;
                        full[g] = eq && s.ch[g].buffer_full_flag;
                    end
                    CBR_ASYNC, CBR_CTRL: begin
                        empty[g] = eq && pc_eq;
                        full[g] = (eq && !pc_eq) || pc_wrap;
                    end
                    default: begin
                        // sync channels rely on the two sub-buffer spacing instead
                        empty[g] = 1'b0;
                        full[g] = 1'b0;
                    end
                endcase
            end
            assign CH_ACTIVE[g] = s.ch[g].active;
        end
    endgenerate

    assign CH_EMPTY = empty;
    assign CH_FULL = full;

    logic wr_req;
    logic rd_req;
    logic gnt_wr;
    logic gnt_rd;
    logic [N-1:0] dt_clr;

    always_comb begin
        logic [CW-1:0] idx;
        logic found;
        cbr_ptr_t np;
        cbr_ptr_t dbase;
        cbr_ptr_t dsub;
        cbr_size_t dsize;
        cbr_ctype_t dtype;
        idx = '0;
        found = 1'b0;
        np = '0;
        dbase = '0;
        dsub = '0;
        dsize = '0;
        dtype = CBR_SYNC;
        dt_clr = '0;
        next_s = s;

        next_s.fs1 = FRAME_SYNC;
        next_s.fs2 = s.fs1;
        next_s.fs3 = s.fs2;

        // descriptor fetch: one request in flight, rotating start point
        next_s.dt_re = 1'b0;
        next_s.dt_p1v = 1'b0;
        next_s.dt_p2v = s.dt_p1v;
        next_s.dt_p2ch = s.dt_p1ch;
        if (!s.dt_p1v && !s.dt_p2v) begin
            for (int i = 0; i < N; i++) begin
                if (!found) begin
                    idx = CW'((int'(s.dt_rr) + i) % N);
                    if (s.dt_pend[idx]) begin
                        found = 1'b1;
                    end
                end
            end
            if (found) begin
                dt_clr[idx] = 1'b1;
                next_s.dt_re = 1'b1;
                next_s.dt_addr = `CBR_DT_DESC_BASE + `CBR_DT_AW'(idx);
                next_s.dt_p1v = 1'b1;
                next_s.dt_p1ch = idx;
                next_s.dt_rr = CW'((int'(idx) + 1) % N);
                next_s.ch[idx].active = 1'b0;
            end
        end
        // a load pulse in the cycle of its own clear is kept
        next_s.dt_pend = (s.dt_pend & ~dt_clr) | CH_LOAD;

        // buffer ram arbitration between media writes and host reads
        wr_req = MEDIA_VALID && (int'(MEDIA_CH) < N) && s.ch[MEDIA_CH].active && !full[MEDIA_CH];
        rd_req = HOST_REQ_VALID && (int'(HOST_REQ_CH) < N) && s.ch[HOST_REQ_CH].active && !empty[HOST_REQ_CH]
                 && fifo_in_ready && !s.rd_p1v && !s.rd_p2v;
        case (s.last)
            CBR_GNT_WR: begin
                gnt_rd = rd_req;
                gnt_wr = wr_req && !rd_req;
            end
            CBR_GNT_RD: begin
                gnt_wr = wr_req;
                gnt_rd = rd_req && !wr_req;
            end
            default: begin
                gnt_wr = 1'b0;
                gnt_rd = 1'b0;
            end
        endcase
        if (gnt_wr) begin
            next_s.last = CBR_GNT_WR;
        end else if (gnt_rd) begin
            next_s.last = CBR_GNT_RD;
        end

        next_s.buf_we = gnt_wr;
        next_s.buf_re = gnt_rd;
        if (gnt_wr) begin
            next_s.buf_addr = s.ch[MEDIA_CH].base + s.ch[MEDIA_CH].write_pointer;
            next_s.buf_wdata = MEDIA_DATA;
            np = ptr_inc(s.ch[MEDIA_CH].write_pointer, s.ch[MEDIA_CH].size);
            next_s.ch[MEDIA_CH].write_pointer = np;
            if (s.ch[MEDIA_CH].ctype == CBR_ISOC && np == s.ch[MEDIA_CH].read_pointer) begin
                next_s.ch[MEDIA_CH].buffer_full_flag = 1'b1;
            end
            if (MEDIA_LAST) begin
                next_s.ch[MEDIA_CH].write_packet_count = s.ch[MEDIA_CH].write_packet_count + 1'b1;
            end
        end
        if (gnt_rd) begin
            next_s.buf_addr = s.ch[HOST_REQ_CH].base + s.ch[HOST_REQ_CH].read_pointer;
            next_s.ch[HOST_REQ_CH].read_pointer =
                ptr_inc(s.ch[HOST_REQ_CH].read_pointer, s.ch[HOST_REQ_CH].size);
            next_s.ch[HOST_REQ_CH].buffer_full_flag = 1'b0;
            if (HOST_REQ_LAST) begin
                next_s.ch[HOST_REQ_CH].read_packet_count = s.ch[HOST_REQ_CH].read_packet_count + 1'b1;
            end
        end
        next_s.rd_p1v = gnt_rd;
        next_s.rd_p1ch = HOST_REQ_CH;
        next_s.rd_p1last = HOST_REQ_LAST;
        next_s.rd_p2v = s.rd_p1v;
        next_s.rd_p2ch = s.rd_p1ch;
        next_s.rd_p2last = s.rd_p1last;

        // frame sync moves both pointers of every active sync channel
        if (s.fs2 && !s.fs3) begin
            for (int c = 0; c < N; c++) begin
                if (s.ch[c].active && s.ch[c].ctype == CBR_SYNC) begin
                    np = ptr_next_sub(s.ch[c].wstart, s.ch[c].sub, s.ch[c].size);
                    next_s.ch[c].wstart = np;
                    next_s.ch[c].write_pointer = np;
                    next_s.ch[c].read_pointer = ptr_rewind(np, s.ch[c].sub, s.ch[c].size);
                end
            end
        end

        // descriptor arrival: channel restarts with fresh pointers
        if (s.dt_p2v) begin
            dtype = cbr_ctype_t'(DT_RDATA[`CBR_DF_TYPE_LSB +: 2]);
            dbase = DT_RDATA[`CBR_DF_BASE_LSB +: `CBR_BUF_AW];
            dsize = DT_RDATA[`CBR_DF_SIZE_LSB +: `CBR_SIZE_W];
            dsub = DT_RDATA[`CBR_DF_SUB_LSB +: `CBR_BUF_AW];
            next_s.ch[s.dt_p2ch].active = DT_RDATA[`CBR_DF_EN_BIT];
            next_s.ch[s.dt_p2ch].ctype = dtype;
            next_s.ch[s.dt_p2ch].base = dbase;
            next_s.ch[s.dt_p2ch].size = dsize;
            next_s.ch[s.dt_p2ch].sub = dsub;
            next_s.ch[s.dt_p2ch].wstart = `CBR_PTR_RST;
            next_s.ch[s.dt_p2ch].write_pointer = `CBR_PTR_RST;
            next_s.ch[s.dt_p2ch].read_pointer = (dtype == CBR_SYNC) ?
                ptr_rewind(`CBR_PTR_RST, dsub, dsize) : `CBR_PTR_RST;
            next_s.ch[s.dt_p2ch].buffer_full_flag = 1'b0;
            next_s.ch[s.dt_p2ch].write_packet_count = `CBR_PC_RST;
            next_s.ch[s.dt_p2ch].read_packet_count = `CBR_PC_RST;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s <= '0;
            s.last <= CBR_GNT_RD;
        end else begin
            s <= next_s;
        end
    end

    assign MEDIA_READY = gnt_wr;
    assign HOST_REQ_READY = gnt_rd;
    assign BUF_ADDR = s.buf_addr;
    assign BUF_WE = s.buf_we;
    assign BUF_RE = s.buf_re;
    assign BUF_WDATA = s.buf_wdata;
    assign DT_ADDR = s.dt_addr;
    assign DT_RE = s.dt_re;

    // read data buffered toward the host port; a full fifo stalls reads
    cbr_fifo #(
        .W(FW),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst_b(RST_B),
        .in_valid(s.rd_p2v),
        .in_ready(fifo_in_ready),
        .in_data({s.rd_p2last, s.rd_p2ch, BUF_RDATA}),
        .out_valid(HOST_VALID),
        .out_ready(HOST_READY),
        .out_data(fifo_out)
    );

    assign HOST_DATA = fifo_out[`CBR_BUF_DW-1:0];
    assign HOST_CH = fifo_out[`CBR_BUF_DW +: CW];
    assign HOST_LAST = fifo_out[FW-1];
endmodule
`default_nettype wire

// ### dv/cbr_routing_fabric_monitor.sv
`default_nettype none
module cbr_routing_fabric_monitor #(
    parameter int N = 4,
    parameter int CW = 2
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // channel status
    input wire logic [N-1:0] CH_ACTIVE,
    input wire logic [N-1:0] CH_EMPTY,
    input wire logic [N-1:0] CH_FULL,
    // media and host ports
    input wire logic MEDIA_VALID,
    input wire logic MEDIA_READY,
    input wire logic [CW-1:0] MEDIA_CH,
    input wire logic [7:0] MEDIA_DATA,
    input wire logic HOST_REQ_VALID,
    input wire logic HOST_REQ_READY,
    input wire logic [CW-1:0] HOST_REQ_CH,
    input wire logic HOST_VALID,
    input wire logic HOST_READY,
    input wire logic [CW-1:0] HOST_CH,
    input wire logic [7:0] HOST_DATA,
    // rams
    input wire logic BUF_WE,
    input wire logic BUF_RE,
    input wire logic [7:0] BUF_WDATA,
    input wire logic [7:0] DT_ADDR,
    input wire logic DT_RE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    a_one_grant: assert property (!(BUF_WE && BUF_RE)) else $error("double buffer grant");
    a_write_issue: assert property (MEDIA_VALID && MEDIA_READY |=>
        BUF_WE && BUF_WDATA == $past(MEDIA_DATA)) else $error("write not issued");
    a_read_issue: assert property (HOST_REQ_VALID && HOST_REQ_READY |=>
        BUF_RE && !HOST_REQ_READY ##1 !HOST_REQ_READY) else $error("read not issued");
    a_no_wr_full: assert property (MEDIA_READY |->
        CH_ACTIVE[MEDIA_CH] && !CH_FULL[MEDIA_CH]) else $error("write into full");
    a_no_rd_empty: assert property (HOST_REQ_READY |->
        CH_ACTIVE[HOST_REQ_CH] && !CH_EMPTY[HOST_REQ_CH]) else $error("read from empty");
    a_flag_excl: assert property ((CH_EMPTY & CH_FULL) == '0) else $error("empty and full");
    a_fetch_slot: assert property (DT_RE |-> DT_ADDR < N && !CH_ACTIVE[DT_ADDR[CW-1:0]]
        ##1 !DT_RE ##1 !DT_RE) else $error("bad descriptor fetch");
    a_host_hold: assert property (HOST_VALID && !HOST_READY |=> HOST_VALID
        && $stable(HOST_DATA) && $stable(HOST_CH)) else $error("host data dropped");
endmodule

bind cbr_routing_fabric cbr_routing_fabric_monitor #(.N(N), .CW(CW)) u_mon (
    .CLK(CLK), .RST_B(RST_B), .CH_ACTIVE(CH_ACTIVE), .CH_EMPTY(CH_EMPTY),
    .CH_FULL(CH_FULL), .MEDIA_VALID(MEDIA_VALID), .MEDIA_READY(MEDIA_READY),
    .MEDIA_CH(MEDIA_CH), .MEDIA_DATA(MEDIA_DATA), .HOST_REQ_VALID(HOST_REQ_VALID),
    .HOST_REQ_READY(HOST_REQ_READY), .HOST_REQ_CH(HOST_REQ_CH), .HOST_VALID(HOST_VALID),
    .HOST_READY(HOST_READY), .HOST_CH(HOST_CH), .HOST_DATA(HOST_DATA), .BUF_WE(BUF_WE),
    .BUF_RE(BUF_RE), .BUF_WDATA(BUF_WDATA), .DT_ADDR(DT_ADDR), .DT_RE(DT_RE));
`default_nettype wire

// ### dv/cbr_ram_model.sv
`default_nettype none
module cbr_ram_model (
    // clock
    input wire logic clk,
    // buffer ram side
    input wire logic [13:0] buf_addr,
    input wire logic buf_we,
    input wire logic buf_re,
    input wire logic [7:0] buf_wdata,
    output logic [7:0] buf_rdata,
    // descriptor ram side
    input wire logic [7:0] dt_addr,
    input wire logic dt_re,
    output logic [127:0] dt_rdata,
    // software writes to the descriptor table
    input wire logic sw_we,
    input wire logic [7:0] sw_addr,
    input wire logic [127:0] sw_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16384];
    logic [127:0] dt [144];
    initial begin
        for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h5A;
        buf_rdata = 8'h00;
        dt_rdata = '0;
    end
    // read data lasts one cycle, then toggles so stale values never match
    always @(posedge clk) begin
        if (buf_we) mem[buf_addr] <= buf_wdata;
        buf_rdata <= buf_re ? mem[buf_addr] : ~buf_rdata;
        dt_rdata <= dt_re ? dt[dt_addr] : ~dt_rdata;
        if (sw_we) dt[sw_addr] <= sw_data;
    end
endmodule
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 0, RST_B = 0, FRAME_SYNC = 0, MEDIA_VALID = 0, MEDIA_LAST = 0, HOST_REQ_VALID = 0;
    logic HOST_REQ_LAST = 0, HOST_READY = 1, sw_we = 0;
    logic [3:0] CH_LOAD = 0, CH_ACTIVE, CH_EMPTY, CH_FULL;
    logic [1:0] MEDIA_CH = 0, HOST_REQ_CH = 0, HOST_CH;
    logic [7:0] MEDIA_DATA = 0, HOST_DATA, BUF_WDATA, BUF_RDATA, DT_ADDR, sw_addr = 0;
    logic [13:0] BUF_ADDR;
    logic [127:0] DT_RDATA, sw_data = 0;
    logic MEDIA_READY, HOST_REQ_READY, HOST_VALID, HOST_LAST, BUF_WE, BUF_RE, DT_RE;
    int num_errors = 0, cmp_count = 0;
    logic [7:0] sh [int];
    always #10 CLK = ~CLK;

    cbr_routing_fabric u_dut (.CLK(CLK), .RST_B(RST_B), .CH_LOAD(CH_LOAD), .FRAME_SYNC(FRAME_SYNC),
        .CH_ACTIVE(CH_ACTIVE), .CH_EMPTY(CH_EMPTY), .CH_FULL(CH_FULL), .MEDIA_VALID(MEDIA_VALID),
        .MEDIA_READY(MEDIA_READY), .MEDIA_CH(MEDIA_CH), .MEDIA_DATA(MEDIA_DATA), .MEDIA_LAST(MEDIA_LAST),
        .HOST_REQ_VALID(HOST_REQ_VALID), .HOST_REQ_READY(HOST_REQ_READY), .HOST_REQ_CH(HOST_REQ_CH),
        .HOST_REQ_LAST(HOST_REQ_LAST), .HOST_VALID(HOST_VALID), .HOST_READY(HOST_READY),
        .HOST_CH(HOST_CH), .HOST_LAST(HOST_LAST), .HOST_DATA(HOST_DATA), .BUF_ADDR(BUF_ADDR),
        .BUF_WE(BUF_WE), .BUF_RE(BUF_RE), .BUF_WDATA(BUF_WDATA), .BUF_RDATA(BUF_RDATA),
        .DT_ADDR(DT_ADDR), .DT_RE(DT_RE), .DT_RDATA(DT_RDATA));
    cbr_ram_model u_ram (.clk(CLK), .buf_addr(BUF_ADDR), .buf_we(BUF_WE), .buf_re(BUF_RE),
        .buf_wdata(BUF_WDATA), .buf_rdata(BUF_RDATA), .dt_addr(DT_ADDR), .dt_re(DT_RE),
        .dt_rdata(DT_RDATA), .sw_we(sw_we), .sw_addr(sw_addr), .sw_data(sw_data));

    task final_report;
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, s, e);
        end
    endtask
    task tmo;
        num_errors++;
        $display("[FAIL] %0t timeout", $time);
        final_report;
    endtask
    function logic [7:0] ed(input logic [13:0] a);
        return sh.exists(a) ? sh[a] : a[7:0] ^ 8'h5A;
    endfunction

    task load(input int ch, input logic [1:0] ty, input logic [13:0] b, input logic [14:0] sz,
              input logic [13:0] sub);
        int i;
        @(negedge CLK);
        sw_we = 1;
        sw_addr = ch[7:0];
        sw_data = {82'h0, 1'b1, sub, sz, b, ty};
        @(negedge CLK);
        sw_we = 0;
        CH_LOAD[ch] = 1;
        @(negedge CLK);
        CH_LOAD = 0;
        for (i = 0; i < 8 && DT_RE !== 1'b1; i++) @(negedge CLK);
        if (DT_RE !== 1'b1) tmo;
        chk(DT_ADDR, ch);
        chk(CH_ACTIVE[ch], 0);
        repeat (2) @(negedge CLK);
        chk(CH_ACTIVE[ch], 1);
    endtask
    task wr(input logic [1:0] ch, input logic [7:0] d, input logic l, input logic [13:0] a);
        int i;
        @(negedge CLK);
        MEDIA_VALID = 1;
        MEDIA_CH = ch;
        MEDIA_DATA = d;
        MEDIA_LAST = l;
        // let the combinational grant settle before looking at it
        #1;
        for (i = 0; i < 20 && MEDIA_READY !== 1'b1; i++) begin
            @(negedge CLK);
            #1;
        end
        if (MEDIA_READY !== 1'b1) tmo;
        @(negedge CLK);
        MEDIA_VALID = 0;
        chk({BUF_WE, BUF_RE, BUF_ADDR}, {2'b10, a});
        chk(BUF_WDATA, d);
        sh[a] = d;
    endtask
    task rd(input logic [1:0] ch, input logic l, input logic [13:0] a, input logic pop);
        int i;
        @(negedge CLK);
        HOST_REQ_VALID = 1;
        HOST_REQ_CH = ch;
        HOST_REQ_LAST = l;
        #1;
        for (i = 0; i < 20 && HOST_REQ_READY !== 1'b1; i++) begin
            @(negedge CLK);
            #1;
        end
        if (HOST_REQ_READY !== 1'b1) tmo;
        @(negedge CLK);
        HOST_REQ_VALID = 0;
        chk({BUF_WE, BUF_RE, BUF_ADDR}, {2'b01, a});
        if (pop) begin
            for (i = 0; i < 8 && HOST_VALID !== 1'b1; i++) @(negedge CLK);
            chk({HOST_VALID, HOST_LAST, HOST_CH, HOST_DATA}, {1'b1, l, ch, ed(a)});
        end
    endtask
    task refuse(input logic m, input logic [1:0] ch);
        @(negedge CLK);
        MEDIA_VALID = m;
        MEDIA_CH = ch;
        HOST_REQ_VALID = !m;
        HOST_REQ_CH = ch;
        #1;
        repeat (3) begin
            chk(m ? MEDIA_READY : HOST_REQ_READY, 0);
            @(negedge CLK);
        end
        MEDIA_VALID = 0;
        HOST_REQ_VALID = 0;
    endtask

    task t_reset;
        repeat (4) @(negedge CLK);
        chk({CH_ACTIVE, BUF_WE, BUF_RE, DT_RE, MEDIA_READY, HOST_REQ_READY, HOST_VALID}, 0);
        RST_B = 1;
    endtask
    task t_iso;
        load(0, 2'h1, 14'h0100, 15'd4, 14'd0);
        chk({CH_EMPTY[0], CH_FULL[0]}, 2'b10);
        for (int i = 0; i < 4; i++) wr(0, 8'h10 + i[7:0], 0, 14'h0100 + i[13:0]);
        chk({CH_EMPTY[0], CH_FULL[0]}, 2'b01);
        refuse(1, 0);
        for (int i = 0; i < 4; i++) rd(0, 0, 14'h0100 + i[13:0], 1);
        chk({CH_EMPTY[0], CH_FULL[0]}, 2'b10);
        refuse(0, 0);
    endtask
    task t_async;
        load(2, 2'h2, 14'h3FFC, 15'd4, 14'd0);
        chk({CH_EMPTY[2], CH_FULL[2]}, 2'b10);
        wr(2, 8'h77, 1, 14'h3FFC);
        rd(2, 0, 14'h3FFC, 1);
        chk({CH_EMPTY[2], CH_FULL[2]}, 2'b01);
        refuse(1, 2);
        load(1, 2'h3, 14'h0200, 15'd4, 14'd0);
        wr(1, 8'h3C, 1, 14'h0200);
        rd(1, 1, 14'h0200, 1);
        chk({CH_EMPTY[1], CH_FULL[1]}, 2'b10);
    endtask
    task t_sync;
        load(3, 2'h0, 14'h0040, 15'd16, 14'd4);
        wr(3, 8'hA1, 0, 14'h0040);
        rd(3, 0, 14'h0048, 1);
        chk({CH_EMPTY[3], CH_FULL[3]}, 0);
        @(negedge CLK);
        FRAME_SYNC = 1;
        repeat (6) @(negedge CLK);
        FRAME_SYNC = 0;
        wr(3, 8'hA2, 0, 14'h0044);
        rd(3, 0, 14'h004C, 1);
    endtask
    task t_fifo;
        int j;
        @(negedge CLK);
        HOST_READY = 0;
        for (int i = 0; i < 16; i++) begin
            j = i + 13;
            rd(3, 0, {10'h004, j[3:0]}, 0);
        end
        refuse(0, 3);
        for (int i = 0; i < 16; i++) begin
            j = i + 13;
            @(negedge CLK);
            chk({HOST_VALID, HOST_CH, HOST_DATA}, {1'b1, 2'd3, ed({10'h004, j[3:0]})});
            HOST_READY = 1;
        end
        @(negedge CLK);
        chk(HOST_VALID, 0);
    endtask

    initial begin
        t_reset;
        t_iso;
        t_async;
        t_sync;
        t_fifo;
        final_report;
    end
endmodule
`default_nettype wire
